// file: dv/dtcc_far_model.sv
`timescale 1ns/1ps
// Far side: low clock oscillator and event pin source
module dtcc_far_model (
  // Clock
  input wire logic clk,
  // Controls
  input wire logic oscRun,
  input wire logic pinRun,
  // Towards the block
  output logic lowFreqTick,
  output logic countPin
);
  // Free divider; a stopped oscillator gives no ticks at all
  logic [2:0] div = 3'h0;
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    lowFreqTick <= oscRun && (div[1:0] == 2'h3);
    // Pin toggles every 8 cycles, so one falling edge per 16
    if (pinRun && div == 3'h7)
      countPin <= ~countPin;
  end
  initial countPin = 1'b1;
  initial lowFreqTick = 1'b0;
endmodule : dtcc_far_model

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
  logic [11:0] adr = 12'h000;
  logic [7:0] dat = 8'h00, q, wbDatO;
  logic wbAck, stopEntry = 0, lowOp = 0, oscOk = 1, lowTick, pin0, lowSrc = 0;
  logic [2:0] sel0 = 3'h7, sel1 = 3'h6;
  logic [1:0] mode0 = 2'h0;
  logic ext0 = 0, out0 = 0, out1 = 0, tick0, pul0, first_pwm_pin, pul1, second_pwm_pin;
  logic tick1, run0, run1, cas;
  int error_cnt = 0, num_checks = 0;
  always #2 clk = ~clk;
  dtcc_far_model u_far (.clk(clk), .oscRun(oscOk), .pinRun(1'b1), .lowFreqTick(lowTick),
    .countPin(pin0));
  dtcc_top u_dut (.clk(clk), .sys_rst(sys_rst), .wbCyc(cyc), .wbStb(stb), .wbWe(we),
    .wbAdr(adr), .wbDatI(dat), .wbSel(1'b1), .wbDatO(wbDatO), .wbAck(wbAck),
    .stopEntry(stopEntry), .lowClockOperation(lowOp), .lowClockSourceSel(lowSrc),
    .lowFreqOscOk(oscOk), .lowFreqTick(lowTick), .firstClockSelect(sel0),
    .secondClockSelect(sel1), .firstMode(mode0), .secondMode(2'h0), .firstExtSel(ext0),
    .secondExtSel(1'b0), .firstExternalCountPin(pin0), .secondExternalCountPin(1'b1),
    .firstTimerOut(out0), .secondTimerOut(out1), .firstTimerRun(run0), .secondTimerRun(run1),
    .cascade(cas), .firstTick(tick0), .secondTick(tick1), .firstPulsePin(pul0),
    .firstPwmPin(first_pwm_pin), .secondPulsePin(pul1), .secondPwmPin(second_pwm_pin));
  // Verdict and end of run
  task report_and_stop;
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Single comparison point
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Classic cycle; held until ack, released after it
  task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    i = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (wbAck !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      error_cnt++;
      report_and_stop();
    end
    q = wbDatO;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask : wb
  // Cycles between two ticks; zero means none in 3000 cycles
  task per(output int n);
    int i;
    i = 0;
    n = 0;
    while (tick0 !== 1'b1 && i < 3000)
    begin
      @(posedge clk);
      i++;
    end
    if (i < 3000)
    begin
      do
      begin
        @(posedge clk);
        n++;
      end
      while (tick0 !== 1'b1 && n < 3000);
    end
  endtask : per
  int n;
  int k;
  int divs [8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    wb(0, 12'h02c, 0); chk(q, 8'h00);
    wb(0, 12'hf74, 0); chk(q, 8'h00);
    wb(0, 12'h123, 0); chk(q, 8'h00);
    // Start with combine and cascade in one write
    wb(1, 12'h02c, 8'hff); wb(0, 12'h02c, 0); chk(q, 8'h0f);
    wb(1, 12'h02c, 8'h03); wb(0, 12'h02c, 0); chk(q, 8'h0f);
    out0 <= 1; out1 <= 0; repeat (3) @(posedge clk);
    chk({pul1, second_pwm_pin, pul0, first_pwm_pin}, 4'h3);
    out1 <= 1; repeat (3) @(posedge clk);
    chk({pul1, second_pwm_pin, pul0, first_pwm_pin}, 4'hf);
    stopEntry <= 1; @(posedge clk); stopEntry <= 0;
    wb(0, 12'h02c, 0); chk(q, 8'h0c);
    wb(1, 12'h02c, 8'h00); wb(0, 12'h02c, 0); chk(q, 8'h00);
    // Outputs that differ, so a stuck combine would show
    out0 <= 0; out1 <= 1; repeat (3) @(posedge clk);
    chk({pul1, second_pwm_pin, pul0, first_pwm_pin}, 4'hc);
    // Ungated pair gets no ticks
    wb(1, 12'h02c, 8'h01); per(n); chk(n, 0);
    wb(1, 12'hf74, 8'h10); wb(0, 12'hf74, 0); chk(q, 8'h10);
    for (int c = 0; c < 8; c++)
    begin
      sel0 <= c[2:0];
      repeat (2) @(posedge clk);
      per(n); per(n); chk(n, divs[c]);
    end
    // Full speed with the low clock behind code 001: eight low ticks
    lowSrc <= 1;
    sel0 <= 3'h1;
    repeat (2) @(posedge clk);
    per(n); per(n); chk(n, 32);
    // Cascade: second select and second run bit drive the pair
    wb(1, 12'h02c, 8'h00);
    wb(1, 12'h02c, 8'h06);
    repeat (4) @(posedge clk);
    chk({run0, run1, cas}, 3'h3);
    n = 0;
    k = 0;
    repeat (16)
    begin
      @(posedge clk);
      n += (tick1 === 1'b1);
      k += (tick0 === 1'b1);
    end
    chk(n, 8);
    chk(k, 0);
    // Back to the first timer alone and running
    wb(1, 12'h02c, 8'h00);
    wb(1, 12'h02c, 8'h01);
    repeat (2) @(posedge clk);
    chk({run0, run1, cas}, 3'h4);
    // Low clock operation: only three codes tick
    lowOp <= 1; sel0 <= 3'h7; repeat (2) @(posedge clk);
    per(n); per(n); chk(n, 16);
    sel0 <= 3'h0; per(n); per(n); chk(n, 64);
    sel0 <= 3'h2; repeat (2) @(posedge clk); per(n); chk(n, 0);
    oscOk <= 0; sel0 <= 3'h7; repeat (8) @(posedge clk); per(n); chk(n, 0);
    // Event mode counts falling pin edges only
    lowOp <= 0; oscOk <= 1; mode0 <= 2'h1; ext0 <= 1; repeat (2) @(posedge clk);
    per(n); per(n); chk(n, 16);
    report_and_stop();
  end
endmodule : testbench

// file: hdl/dtcc_pkg.sv
package dtcc_pkg;
  localparam logic [11:0] DTCC_CTRL_ADDR = 12'h02c;
  localparam logic [11:0] DTCC_GATE_ADDR = 12'hf74;
  localparam logic [7:0] DTCC_CTRL_RST = 8'h00;
  localparam logic [7:0] DTCC_GATE_RST = 8'h00;
  localparam int DTCC_RUN0_BIT = 0;
  localparam int DTCC_RUN1_BIT = 1;
  localparam int DTCC_CAS_BIT = 2;
  localparam int DTCC_AND_BIT = 3;
  localparam int DTCC_PAIR_GATE_BIT = 4;
  localparam int DTCC_PRESC_W = 11;
  // Mode families for source selection
  typedef enum logic [1:0] {
    DTCC_MODE_TIMER = 2'b00,
    DTCC_MODE_EVENT = 2'b01,
    DTCC_MODE_PWM = 2'b10,
    DTCC_MODE_PPG = 2'b11
  } dtcc_mode_t;
  // Bus answer states
  typedef enum logic [0:0] {
    DTCC_BUS_IDLE = 1'b0,
    DTCC_BUS_ACK = 1'b1
  } dtcc_bus_t;
endpackage : dtcc_pkg

// file: hdl/dtcc_top.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module dtcc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Classic Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [11:0] wbAdr,
  input wire logic [7:0] wbDatI,
  input wire logic [0:0] wbSel,
  output logic [7:0] wbDatO,
  output logic wbAck,
  // Power state
  input wire logic stopEntry,
  input wire logic lowClockOperation,
  input wire logic lowClockSourceSel,
  input wire logic lowFreqOscOk,
  input wire logic lowFreqTick,
  // Per-timer mode and clock selection
  input wire logic [2:0] firstClockSelect,
  input wire logic [2:0] secondClockSelect,
  input wire logic [1:0] firstMode,
  input wire logic [1:0] secondMode,
  input wire logic firstExtSel,
  input wire logic secondExtSel,
  input wire logic firstExternalCountPin,
  input wire logic secondExternalCountPin,
  // Raw timer outputs from the counting cores
  input wire logic firstTimerOut,
  input wire logic secondTimerOut,
  // Control towards the counting cores
  output logic firstTimerRun,
  output logic secondTimerRun,
  output logic cascade,
  output logic firstTick,
  output logic secondTick,
  // Pins
  output logic firstPulsePin,
  output logic firstPwmPin,
  output logic secondPulsePin,
  output logic secondPwmPin
);
  // Control and gate registers
  logic [3:0] ctrl;
  logic [7:0] gate;
  logic [3:0] next_ctrl;
  logic [7:0] next_gate;
  // Bus state
  dtcc_pkg::dtcc_bus_t busState;
  dtcc_pkg::dtcc_bus_t next_busState;
  logic [7:0] next_wbDatO;
  // Prescaler and edge history
  logic [dtcc_pkg::DTCC_PRESC_W-1:0] presc;
  logic [dtcc_pkg::DTCC_PRESC_W-1:0] next_presc;
  logic [3:0] lowPresc;
  logic [3:0] next_lowPresc;
  logic [1:0] pinPrev;
  logic [1:0] next_pinPrev;
  logic next_firstTick;
  logic next_secondTick;
  logic [3:0] next_pins;
  logic [dtcc_pkg::DTCC_PRESC_W-1:0] prescInc;
  logic [3:0] lowInc;
  logic req;
  logic pairOn;

  // Tick when the counter's low bits all reach one (rollover of bit n)
  function automatic logic divTick(input logic [dtcc_pkg::DTCC_PRESC_W-1:0] p,
                                   input logic [3:0] lp, input logic [2:0] sel,
                                   input logic lowOp, input logic lowSrc,
                                   input logic oscOk, input logic lowT);
    logic t;
    t = 1'b0;
    if (lowOp)
    begin
      // Only three codes give a clock in low-clock operation
      case (sel)
        3'h0: t = lowT && (&lp[3:0]);
        3'h1: t = lowT && (&lp[2:0]);
        3'h7: t = lowT && (&lp[1:0]);
        default: t = 1'b0;
      endcase
      t = t && oscOk;
    end
    else
    begin
      case (sel)
        3'h0: t = lowSrc ? (oscOk && lowT && (&lp[3:0])) : (&p[10:0]);
        3'h1: t = lowSrc ? (oscOk && lowT && (&lp[2:0])) : (&p[9:0]);
        3'h2: t = &p[7:0];
        3'h3: t = &p[5:0];
        3'h4: t = &p[3:0];
        3'h5: t = &p[1:0];
        3'h6: t = p[0];
        3'h7: t = 1'b1;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction : divTick

  // Source choice per mode family
  function automatic logic pickSrc(input logic [1:0] mode, input logic ext,
                                   input logic internal, input logic edgeT,
                                   input logic wide);
    logic s;
    s = 1'b0;
    case (mode)
      dtcc_pkg::DTCC_MODE_EVENT: s = edgeT;
      dtcc_pkg::DTCC_MODE_TIMER: s = internal;
      default: s = (wide && ext) ? edgeT : internal;
    endcase
    return s;
  endfunction : pickSrc

  assign req = wbCyc && wbStb && (busState == dtcc_pkg::DTCC_BUS_IDLE);
  assign pairOn = gate[dtcc_pkg::DTCC_PAIR_GATE_BIT];

  // Register writes, run control and stop-mode clearing
  always_comb
  begin
    next_ctrl = ctrl;
    next_gate = gate;
    if (req && wbWe && wbSel[0])
    begin
      if (wbAdr == dtcc_pkg::DTCC_GATE_ADDR)
      begin
        next_gate = wbDatI;
      end
      else if (wbAdr == dtcc_pkg::DTCC_CTRL_ADDR)
      begin
        next_ctrl[1:0] = wbDatI[1:0];
        // Config locked unless both stopped, judged on pre-write run state
        if (ctrl[1:0] == 2'b00)
        begin
          next_ctrl[3:2] = wbDatI[3:2];
        end
      end
    end
    if (stopEntry)
    begin
      next_ctrl[1:0] = 2'b00;
    end
  end

  // Bus answer: one ack one cycle after the request, then idle
  always_comb
  begin
    next_busState = dtcc_pkg::DTCC_BUS_IDLE;
    next_wbDatO = wbDatO;
    if (req)
    begin
      next_busState = dtcc_pkg::DTCC_BUS_ACK;
      if (wbAdr == dtcc_pkg::DTCC_CTRL_ADDR)
      begin
        next_wbDatO = {4'h0, ctrl};
      end
      else if (wbAdr == dtcc_pkg::DTCC_GATE_ADDR)
      begin
        next_wbDatO = gate;
      end
      else
      begin
        next_wbDatO = 8'h00;
      end
    end
  end

  // Prescalers, tick selection and pin combining
  always_comb
  begin
    prescInc = presc + 1'b1;
    lowInc = lowPresc + 1'b1;
    next_presc = presc;
    next_lowPresc = lowPresc;
    next_pinPrev = {secondExternalCountPin, firstExternalCountPin};
    next_firstTick = 1'b0;
    next_secondTick = 1'b0;
    if (pairOn)
    begin
      next_presc = prescInc;
      if (lowFreqTick && lowFreqOscOk)
      begin
        next_lowPresc = lowInc;
      end
      if (ctrl[dtcc_pkg::DTCC_CAS_BIT])
      begin
        // Wide modes: second select, first pin, second run bit
        next_secondTick = ctrl[dtcc_pkg::DTCC_RUN1_BIT] && pickSrc(secondMode, firstExtSel,
          divTick(presc, lowPresc, secondClockSelect, lowClockOperation, lowClockSourceSel,
          lowFreqOscOk, lowFreqTick), pinPrev[0] && !firstExternalCountPin, 1'b1);
      end
      else
      begin
        next_firstTick = ctrl[dtcc_pkg::DTCC_RUN0_BIT] && pickSrc(firstMode, firstExtSel,
          divTick(presc, lowPresc, firstClockSelect, lowClockOperation, lowClockSourceSel,
          lowFreqOscOk, lowFreqTick), pinPrev[0] && !firstExternalCountPin, 1'b0);
        next_secondTick = ctrl[dtcc_pkg::DTCC_RUN1_BIT] && pickSrc(secondMode, secondExtSel,
          divTick(presc, lowPresc, secondClockSelect, lowClockOperation, lowClockSourceSel,
          lowFreqOscOk, lowFreqTick), pinPrev[1] && !secondExternalCountPin, 1'b0);
      end
    end
    if (ctrl[dtcc_pkg::DTCC_AND_BIT])
    begin
      // First pins idle high; second pins carry the AND
      next_pins = {secondTimerOut && firstTimerOut, secondTimerOut && firstTimerOut,
                   1'b1, 1'b1};
    end
    else
    begin
      next_pins = {secondTimerOut, secondTimerOut, firstTimerOut, firstTimerOut};
    end
  end

  // All state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl <= dtcc_pkg::DTCC_CTRL_RST[3:0];
      gate <= dtcc_pkg::DTCC_GATE_RST;
      busState <= dtcc_pkg::DTCC_BUS_IDLE;
      wbDatO <= 8'h00;
      wbAck <= 1'b0;
      presc <= '0;
      lowPresc <= 4'h0;
      pinPrev <= 2'b11;
      firstTick <= 1'b0;
      secondTick <= 1'b0;
      firstTimerRun <= 1'b0;
      secondTimerRun <= 1'b0;
      cascade <= 1'b0;
      firstPulsePin <= 1'b0;
      firstPwmPin <= 1'b0;
      secondPulsePin <= 1'b0;
      secondPwmPin <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      gate <= next_gate;
      busState <= next_busState;
      wbDatO <= next_wbDatO;
      wbAck <= (next_busState == dtcc_pkg::DTCC_BUS_ACK);
      presc <= next_presc;
      lowPresc <= next_lowPresc;
      pinPrev <= next_pinPrev;
      firstTick <= next_firstTick;
      secondTick <= next_secondTick;
      // Run outputs follow register, first run held low in cascade; a run bit left at 1 clears counter when cleared
      firstTimerRun <= next_ctrl[dtcc_pkg::DTCC_RUN0_BIT] && !next_ctrl[dtcc_pkg::DTCC_CAS_BIT];
      secondTimerRun <= next_ctrl[dtcc_pkg::DTCC_RUN1_BIT];
      cascade <= next_ctrl[dtcc_pkg::DTCC_CAS_BIT];
      secondPwmPin <= next_pins[3];
      secondPulsePin <= next_pins[2];
      firstPwmPin <= next_pins[1];
      firstPulsePin <= next_pins[0];
    end
  end

  // Checks
  sequence runWrite;
    req && wbWe && wbSel[0] && (wbAdr == dtcc_pkg::DTCC_CTRL_ADDR) && !stopEntry;
  endsequence

  chk_lock_while_run: assert property (@(posedge clk) disable iff (sys_rst)
    (runWrite and (ctrl[1:0] != 2'b00)) |=> $stable(ctrl[3:2]))
    else $error("config changed while running");
  chk_start_takes_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    (runWrite and (ctrl[1:0] == 2'b00)) |=> (ctrl[3:2] == $past(wbDatI[3:2])))
    else $error("start write lost config");
  chk_run_written: assert property (@(posedge clk) disable iff (sys_rst)
    runWrite |=> (ctrl[1:0] == $past(wbDatI[1:0])))
    else $error("run bits not written");
  chk_stop_clears: assert property (@(posedge clk) disable iff (sys_rst)
    stopEntry |=> (ctrl[1:0] == 2'b00) ##1 !firstTick && !secondTick)
    else $error("stop mode did not clear run");
  chk_read_upper: assert property (@(posedge clk) disable iff (sys_rst)
    (req && (wbAdr == dtcc_pkg::DTCC_CTRL_ADDR)) |=> wbAck && (wbDatO[7:4] == 4'h0))
    else $error("control read bad");
  chk_first_high: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl[dtcc_pkg::DTCC_AND_BIT] |=> firstPulsePin && firstPwmPin)
    else $error("first pins not high");
  chk_and_out: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl[dtcc_pkg::DTCC_AND_BIT] |=>
      (secondPwmPin == ($past(firstTimerOut) && $past(secondTimerOut))))
    else $error("combined output wrong");
  chk_gate_off: assert property (@(posedge clk) disable iff (sys_rst)
    !pairOn |=> !firstTick && !secondTick && $stable(presc))
    else $error("ticks with gate off");
  chk_low_none: assert property (@(posedge clk) disable iff (sys_rst)
    (lowClockOperation && !ctrl[2] && firstMode == dtcc_pkg::DTCC_MODE_TIMER
     && !(firstClockSelect inside {3'h0, 3'h1, 3'h7})) |=> !firstTick)
    else $error("tick from unusable code");
  chk_cascade_first: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl[dtcc_pkg::DTCC_CAS_BIT] |=> !firstTick)
    else $error("first ticks in cascade");
  chk_dead_osc: assert property (@(posedge clk) disable iff (sys_rst)
    (!lowFreqOscOk && lowClockOperation && firstMode == dtcc_pkg::DTCC_MODE_TIMER
     && secondMode == dtcc_pkg::DTCC_MODE_TIMER) |=> !firstTick && !secondTick)
    else $error("tick with dead low clock");
endmodule : dtcc_top
